//--- bench/ews_bus_master.sv
// behavioural two-wire bus master: drives the clock, pulls data low or releases it
`timescale 1ns/1ps
module ews_bus_master (
  // bus lines
  output logic scl,
  output logic pullLow,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    pullLow = 1'b0;
  end
  // data moves well after the clock falls, so the slave filter never sees it as a condition
  // pins move by non-blocking assignment so the slave's sampling edge never races them
  task automatic bitOut(input logic b, output logic r);
    #200 pullLow <= !b;
    #400 scl <= 1'b1;
    #150 r = sda;
    #50 scl <= 1'b0;
  endtask
  // long release before the clock rises: the slave may still hold its ack low
  task automatic start();
    pullLow <= 1'b0;
    #600 scl <= 1'b1;
    #400 pullLow <= 1'b1;
    #400 scl <= 1'b0;
  endtask
  task automatic stop();
    #200 pullLow <= 1'b1;
    #400 scl <= 1'b1;
    #400 pullLow <= 1'b0;
    #400;
  endtask
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitOut(b[i], r);
    bitOut(1'b1, r);
    ack = !r;
  endtask
  task automatic readByte(input logic ackIt, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitOut(1'b1, d[i]);
    bitOut(!ackIt, r);
  endtask
  task automatic recover();
    logic r;
    start();
    repeat (9) bitOut(1'b1, r);
    start();
    stop();
  endtask
endmodule

//--- bench/ews_front_end_asserts.sv
// concurrent checks on the ports of the two-wire memory slave front end
`timescale 1ns/1ps
module ews_front_end_asserts import ews_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // pins
  input wire logic sclIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic writeBusy,
  // streams
  input wire logic cmdStrobe,
  input wire ews_rx_s rxData,
  input wire logic rxValid,
  input wire logic rxReady,
  input wire logic [7:0] txData,
  input wire logic txValid,
  input wire logic txReady,
  // status
  input wire logic standby,
  input wire logic startPulse,
  input wire logic stopPulse
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic txMsb;
  assign txMsb = txData[7];
  chk_open_drain: assert property (sdaOut == 1'b0)
    else $error("data pin driven high");
  chk_idle_release: assert property (standby |-> !sdaOe)
    else $error("data pulled in standby");
  chk_start_wakes: assert property (startPulse |-> ##[0:1] (!standby && !sdaOe))
    else $error("start did not wake");
  chk_stop_sleep: assert property (stopPulse |-> ##[0:1] standby)
    else $error("stop did not sleep");
  chk_strobe_acked: assert property (cmdStrobe |-> ##[0:1] sdaOe)
    else $error("command without ack");
  chk_busy_no_ack: assert property (writeBusy |-> !$rose(sdaOe))
    else $error("ack while busy");
  chk_first_bit: assert property (txReady |=> sdaOe == ($past(txValid) && !$past(txMsb)))
    else $error("wrong first read bit");
  chk_rx_hold: assert property (rxValid && !rxReady |=> rxValid && $stable(rxData))
    else $error("stalled word lost");
  chk_pull_low: assert property ($rose(sdaOe) |-> !sclIn)
    else $error("data changed with clock high");
  cov_start: cover property (startPulse);
  cov_read: cover property (txReady && txValid);
  cov_stall: cover property (rxValid && !rxReady);
endmodule
bind ews_front_end ews_front_end_asserts u_chk (.clock, .rst, .sclIn, .sdaOut, .sdaOe,
  .writeBusy, .cmdStrobe, .rxData, .rxValid, .rxReady, .txData, .txValid, .txReady,
  .standby, .startPulse, .stopPulse);

//--- bench/tb_ews_front_end.sv
// self-checking bench of the two-wire memory slave front end
`timescale 1ns/1ps
module tb_ews_front_end import ews_pkg::*; ;
  // type identifier; value is arbitrary
  localparam logic [3:0] TID = 4'h5;
  logic clock = 1'b0, rst = 1'b1, ce = 1'b1, hwSelectBit = 1'b0, writeBusy = 1'b0;
  logic rxReady = 1'b1, txValid = 1'b1, mOe, ack, r;
  logic [7:0] txData = 8'h3c;
  logic [31:0] lfsr = 32'he50c506b;
  logic sdaOe, sdaOut, cmdStrobe, rxValid, txReady, standby, busIdle, startPulse, stopPulse;
  wire logic sclIn;
  wire logic sdaIn = !(sdaOe || mOe);
  ews_cmd_s cmd;
  ews_rx_s rxData;
  ews_rx_s rxGot[$];
  logic [7:0] txSent[$];
  logic [7:0] d[3];
  logic [7:0] b;
  logic [9:0] wa;
  logic [31:0] t, tt;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  always #50 clock = ~clock;
  ews_bus_master m (.scl(sclIn), .pullLow(mOe), .sda(sdaIn));
  ews_front_end #(.TYPE_ID(TID), .RX_DEPTH(2)) dut (.clock, .rst, .ce, .sclIn, .sdaIn,
    .sdaOut, .sdaOe, .hwSelectBit, .writeBusy, .cmd, .cmdStrobe, .rxData, .rxValid,
    .rxReady, .txData, .txValid, .txReady, .standby, .busIdle, .startPulse, .stopPulse);
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [7:0] devByte(logic [3:0] id, logic s, logic [1:0] hi, logic rw);
    return {id, s, hi, rw};
  endfunction
  task automatic check(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clock);
  endtask
  // consumer and read-data source; a missing byte is sent as all ones
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
    if (rxValid === 1'b1 && rxReady === 1'b1) rxGot.push_back(rxData);
    if (txReady === 1'b1) begin
      txSent.push_back(txValid ? txData : IDLE_READ_BYTE);
      tt = rnd();
      txData <= tt[7:0];
    end
  end
  initial begin
    tick(20);
    rst <= 1'b0;
    tick(5);
    check(standby, 1);
    check(busIdle, 1);
    for (int k = 0; k < 2; k++) begin
      t = rnd();
      wa = t[9:0];
      hwSelectBit <= k[0];
      rxReady <= 1'b0;
      m.start();
      tick(5);
      check(busIdle, 0);
      m.sendByte(devByte(TID, k[0], wa[9:8], 1'b0), ack);
      check(ack, 1);
      m.sendByte(wa[7:0], ack);
      check(ack, 1);
      check(cmd, {wa, 1'b0});
      for (int j = 0; j < 3; j++) begin
        t = rnd();
        d[j] = t[7:0];
        m.sendByte(d[j], ack);
        check(ack, j < 2);
      end
      m.stop();
      tick(4);
      check(standby, 1);
      rxReady <= 1'b1;
      tick(6);
      for (int j = 0; j < 2; j++) check(rxGot.pop_front(), {d[j], wa});
    end
    // one flipped identifier bit at a time, then the wrong select bit
    for (int k = 0; k < 5; k++) begin
      b = (k < 4) ? devByte(TID ^ (4'b0001 << k), 1'b1, 2'b00, 1'b0)
        : devByte(TID, 1'b0, 2'b11, 1'b1);
      m.start();
      m.sendByte(b, ack);
      check(ack, 0);
      tick(8);
      check(standby, 1);
    end
    m.stop();
    tick(1);
    writeBusy <= 1'b1;
    m.start();
    m.sendByte(devByte(TID, 1'b1, 2'b01, 1'b0), ack);
    check(ack, 0);
    m.stop();
    tick(1);
    writeBusy <= 1'b0;
    m.start();
    repeat (4) m.bitOut(1'b0, r);
    m.start();
    t = rnd();
    wa = t[9:0];
    m.sendByte(devByte(TID, 1'b1, wa[9:8], 1'b0), ack);
    check(ack, 1);
    m.sendByte(wa[7:0], ack);
    m.start();
    m.sendByte(devByte(TID, 1'b1, wa[9:8], 1'b1), ack);
    check(ack, 1);
    check(cmd, {wa, 1'b1});
    for (int j = 0; j < 3; j++) begin
      m.readByte(j < 2, b);
      tick(1);
      txValid <= (j != 0);
      check(b, txSent.pop_front());
    end
    tick(8);
    check(standby, 1);
    m.stop();
    // clocking without a start must be ignored
    m.sendByte(8'hff, ack);
    m.sendByte(devByte(TID, 1'b1, 2'b00, 1'b0), ack);
    check(ack, 0);
    m.recover();
    m.start();
    m.sendByte(devByte(TID, 1'b1, 2'b10, 1'b1), ack);
    check(ack, 1);
    m.readByte(1'b0, b);
    check(b, txSent.pop_front());
    m.stop();
    tick(4);
    check(standby, 1);
    final_report();
  end
endmodule

//--- core/ews_front_end.sv
// two-wire serial memory slave front end: conditions, byte shifting, ack and addressing
`timescale 1ns/1ps
module ews_front_end import ews_pkg::*; #(
  // device type identifier; value is arbitrary
  parameter logic [3:0] TYPE_ID = 4'h5,
  parameter int RX_DEPTH = 2
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // bus pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // strap and write engine
  input wire logic hwSelectBit,
  input wire logic writeBusy,
  // assembled command
  output ews_cmd_s cmd,
  output logic cmdStrobe,
  // received write bytes
  output ews_rx_s rxData,
  output logic rxValid,
  input wire logic rxReady,
  // bytes to send on reads
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady,
  // status
  output logic standby,
  output logic busIdle,
  output logic startPulse,
  output logic stopPulse
);
  ews_fe_state_s st;
  ews_fe_state_s next_st;
  logic [PIN_COUNT-1:0] pinRaw;
  logic sclRise;
  logic sclFall;
  logic sdaRise;
  logic sdaFall;
  logic sclHigh;
  logic startSeen;
  logic stopSeen;
  logic byteDone;
  logic typeMatch;
  logic pushValid;
  logic pushReady;
  logic [7:0] loadByte;
  ews_rx_s pushData;

  assign pinRaw[PIN_SCL] = sclIn;
  assign pinRaw[PIN_SDA] = sdaIn;
  // a floating select pad is pulled low outside, so an open strap samples as zero
  assign pinRaw[PIN_SEL] = hwSelectBit; // [R22]

  assign sdaOut = 1'b0; // [R25]
  assign sdaOe = st.sdaOe; // [R25]
  assign cmd = st.cmd;
  assign cmdStrobe = st.cmdStrobe;
  assign startPulse = st.startPulse;
  assign stopPulse = st.stopPulse;
  assign standby = st.phase == ST_IDLE; // [R14]
  assign busIdle = st.level[PIN_SCL] && st.level[PIN_SDA]; // [R9]
  assign loadByte = txValid ? txData : IDLE_READ_BYTE;

  ews_pair_buffer #(
    .WIDTH($bits(ews_rx_s)),
    .DEPTH(RX_DEPTH)
  ) rxBuffer (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .inValid(pushValid),
    .inData(pushData),
    .inReady(pushReady),
    .outValid(rxValid),
    .outData(rxData),
    .outReady(rxReady)
  );

  always_comb begin
    next_st = st;
    next_st.cmdStrobe = 1'b0;
    next_st.startPulse = 1'b0;
    next_st.stopPulse = 1'b0;
    txReady = 1'b0;
    pushValid = 1'b0;
    pushData = '{data: st.rxShift, wordAddr: st.cmd.wordAddr};

    // a change counts only once the second and third stages agree
    for (int i = 0; i < PIN_COUNT; i++) begin
      next_st.sync[i] = {st.sync[i][SYNC_STAGES-2:0], pinRaw[i]};
      if (st.sync[i][1] == st.sync[i][2]) begin
        next_st.level[i] = st.sync[i][2];
      end
    end

    sclRise = next_st.level[PIN_SCL] && !st.level[PIN_SCL];
    sclFall = !next_st.level[PIN_SCL] && st.level[PIN_SCL];
    sdaRise = next_st.level[PIN_SDA] && !st.level[PIN_SDA];
    sdaFall = !next_st.level[PIN_SDA] && st.level[PIN_SDA];
    sclHigh = next_st.level[PIN_SCL] && st.level[PIN_SCL];
    startSeen = sdaFall && sclHigh; // [R5] [R4]
    stopSeen = sdaRise && sclHigh; // [R7] [R4]
    byteDone = sclFall && (st.bitCnt == BIT_CNT_W'(BYTE_BITS)); // [R3]
    typeMatch = (st.rxShift[DA_TYPE_MSB:DA_TYPE_LSB] == TYPE_ID) && // [R17]
      (st.rxShift[DA_SEL_BIT] == st.level[PIN_SEL]); // [R17] [R22]

    if (startSeen) begin
      // a start anywhere, repeated or mid-byte, drops the transfer and reads a new address
      next_st.phase = ST_DEVADDR; // [R5] [R8] [R24]
      next_st.bitCnt = '0;
      next_st.sdaOe = 1'b0;
      next_st.startPulse = 1'b1;
    end else if (stopSeen) begin
      next_st.phase = ST_IDLE; // [R7] [R14] [R24]
      next_st.bitCnt = '0;
      next_st.sdaOe = 1'b0;
      next_st.stopPulse = (st.phase != ST_IDLE);
    end else begin
      case (st.phase)
        ST_IDLE: begin
          // nothing but a start leaves standby
          next_st.sdaOe = 1'b0; // [R6]
        end
        ST_DEVADDR, ST_WORDADDR, ST_WRDATA: begin
          if (sclRise) begin
            next_st.rxShift = {st.rxShift[6:0], next_st.level[PIN_SDA]}; // [R1] [R2]
            next_st.bitCnt = st.bitCnt + 1'b1;
          end else if (byteDone) begin
            next_st.bitCnt = '0;
            if (st.phase == ST_DEVADDR) begin
              if (typeMatch && !writeBusy) begin
                next_st.sdaOe = 1'b1; // [R20] [R11]
                next_st.phase = ST_DEVACK;
                next_st.cmd.wordAddr[ADDR_W-1] = st.rxShift[DA_WORD_ADDR_BIT_NINE]; // [R18]
                next_st.cmd.wordAddr[ADDR_W-2] = st.rxShift[DA_WORD_ADDR_BIT_EIGHT]; // [R18]
                next_st.cmd.readNotWrite = st.rxShift[DA_RW_BIT]; // [R19]
                next_st.after = st.rxShift[DA_RW_BIT] ? ST_RDDATA : ST_WORDADDR; // [R19]
                // a read has no word address byte, so the command is complete now
                next_st.cmdStrobe = st.rxShift[DA_RW_BIT];
              end else begin
                // busy or foreign address: leave the line released and sleep
                next_st.sdaOe = 1'b0; // [R20] [R23]
                next_st.phase = ST_IDLE; // [R14]
              end
            end else if (st.phase == ST_WORDADDR) begin
              next_st.cmd.wordAddr[7:0] = st.rxShift; // [R21]
              next_st.cmdStrobe = 1'b1;
              next_st.sdaOe = 1'b1; // [R3] [R11]
              next_st.phase = ST_WORDACK;
              next_st.after = ST_WRDATA;
            end else begin
              // a full buffer refuses the byte with a nack instead of losing it
              pushValid = 1'b1;
              next_st.sdaOe = pushReady; // [R3] [R11]
              next_st.phase = ST_WRACK;
              next_st.after = ST_WRDATA; // [R10]
            end
          end
        end
        ST_DEVACK, ST_WORDACK, ST_WRACK: begin
          if (sclFall) begin
            next_st.sdaOe = 1'b0; // [R12]
            next_st.phase = st.after;
            next_st.bitCnt = '0;
            if (st.after == ST_RDDATA) begin
              // first read bit goes out on the same falling edge that ends the ack
              txReady = 1'b1;
              next_st.txShift = loadByte;
              next_st.sdaOe = !loadByte[7]; // [R1] [R2] [R25]
            end
          end
        end
        ST_RDDATA: begin
          if (sclRise) begin
            next_st.bitCnt = st.bitCnt + 1'b1;
          end else if (byteDone) begin
            next_st.sdaOe = 1'b0; // [R11]
            next_st.phase = ST_RDACK;
          end else if (sclFall) begin
            next_st.txShift = {st.txShift[6:0], 1'b1};
            next_st.sdaOe = !st.txShift[6]; // [R1] [R2] [R4]
          end
        end
        ST_RDACK: begin
          if (sclRise) begin
            if (next_st.level[PIN_SDA]) begin
              next_st.phase = ST_IDLE; // [R13] [R14]
              next_st.sdaOe = 1'b0; // [R13]
            end
          end else if (sclFall) begin
            txReady = 1'b1;
            next_st.txShift = loadByte;
            next_st.sdaOe = !loadByte[7]; // [R1] [R10]
            next_st.phase = ST_RDDATA;
            next_st.bitCnt = '0;
          end
        end
        default: begin
          next_st.phase = ST_IDLE;
          next_st.sdaOe = 1'b0;
        end
      endcase
    end
  end

  // state resets to standby with both lines taken as high
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= FE_RESET; // [R14]
    end else if (ce) begin
      st <= next_st;
    end
  end

endmodule

//--- core/ews_pair_buffer.sv
// small valid/ready buffer that holds received bytes while the consumer stalls
`timescale 1ns/1ps
module ews_pair_buffer #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // filling side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // draining side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic [CNT_W-1:0] count;
  } ews_buf_state_s;

  ews_buf_state_s st;
  ews_buf_state_s next_st;
  logic push;
  logic pop;

  assign inReady = st.count != FULL_CNT;
  assign outValid = st.count != '0;
  assign outData = st.mem[st.rdPtr];

  always_comb begin
    next_st = st;
    push = inValid && inReady;
    pop = outValid && outReady;
    if (push) begin
      next_st.mem[st.wrPtr] = inData;
      next_st.wrPtr = (st.wrPtr == LAST_PTR) ? '0 : st.wrPtr + 1'b1;
    end
    if (pop) begin
      next_st.rdPtr = (st.rdPtr == LAST_PTR) ? '0 : st.rdPtr + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

endmodule

//--- core/ews_pkg.sv
// shared constants, types and reset values of the two-wire memory slave front end
// Rules for the device and its bus
// [R1] sample data on rising clock edges, change outgoing data only on falling edges
// [R2] every byte moves most significant bit first, one bit per clock
// [R3] receiver answers each eight bits with ack or nack in a ninth clock
// [R4] data changes only while clock low; change during clock high is start or stop
// [R5] start is data falling with clock high; it wakes the device and begins a command
// [R6] when idle, watch for start and ignore all other bus activity
// [R7] stop is data rising with clock high; it ends transfer and enters standby
// [R8] a repeated start is accepted as the beginning of a new command
// [R9] bus counts as idle only while clock and data are both high
// [R10] no limit on bytes between start and stop; master decides the count
// [R11] transmitter releases data after eighth bit; receiver holds low during ninth high
// [R12] receiver releases data at the end of the ninth clock
// [R13] master nack on read data makes the device release data for a stop
// [R14] standby after power-up, plain stop, write end, address mismatch or read nack
// [R15] master recovers bus with start, nine clocks, then start and stop
// [R16] array is 64 pages of 16 bytes, 1024 locations in total
// [R17] address byte bits 7..4 hold type identifier; bit 3 must equal select strap
// [R18] address byte bits 2 and 1 give word address bits nine and eight
// [R19] address byte bit 0 selects direction: one reads, zero writes
// [R20] ack address byte on full match, otherwise nack and return to standby
// [R21] byte after address byte gives word address bits seven to zero
// [R22] unconnected select input counts as zero, so the select bit must be zero
// [R23] while an internal write runs, no address byte is acknowledged
// [R24] start or stop inside a byte or ack slot abandons the current transfer
// [R25] data line is only pulled low or released, never driven high
package ews_pkg;

  localparam int BYTE_BITS = 8;
  localparam int BIT_CNT_W = 4;
  localparam int PAGE_COUNT = 64;
  localparam int PAGE_BYTES = 16;
  localparam int ADDR_W = $clog2(PAGE_COUNT * PAGE_BYTES); // [R16]
  localparam int SYNC_STAGES = 3;
  localparam int PIN_COUNT = 3;

  // pin order inside the synchroniser bank
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_SEL = 2;

  // device address byte layout
  localparam int DA_TYPE_MSB = 7;
  localparam int DA_TYPE_LSB = 4;
  localparam int DA_SEL_BIT = 3;
  localparam int DA_WORD_ADDR_BIT_NINE = 2;
  localparam int DA_WORD_ADDR_BIT_EIGHT = 1;
  localparam int DA_RW_BIT = 0;

  localparam logic [7:0] IDLE_READ_BYTE = 8'hff;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_DEVADDR = 4'b0001,
    ST_DEVACK = 4'b0010,
    ST_WORDADDR = 4'b0011,
    ST_WORDACK = 4'b0100,
    ST_WRDATA = 4'b0101,
    ST_WRACK = 4'b0110,
    ST_RDDATA = 4'b0111,
    ST_RDACK = 4'b1000
  } ews_phase_e;

  typedef struct packed {
    logic [ADDR_W-1:0] wordAddr;
    logic readNotWrite;
  } ews_cmd_s;

  typedef struct packed {
    logic [7:0] data;
    logic [ADDR_W-1:0] wordAddr;
  } ews_rx_s;

  typedef struct packed {
    logic [PIN_COUNT-1:0][SYNC_STAGES-1:0] sync;
    logic [PIN_COUNT-1:0] level;
    ews_phase_e phase;
    ews_phase_e after;
    logic [BIT_CNT_W-1:0] bitCnt;
    logic [7:0] rxShift;
    logic [7:0] txShift;
    logic sdaOe;
    ews_cmd_s cmd;
    logic cmdStrobe;
    logic startPulse;
    logic stopPulse;
  } ews_fe_state_s;

  localparam logic [SYNC_STAGES-1:0] SYNC_HIGH = '1;
  localparam logic [SYNC_STAGES-1:0] SYNC_LOW = '0;

  // lines rest high after reset, select strap low, device in standby
  localparam ews_fe_state_s FE_RESET = '{
    sync: '{SYNC_LOW, SYNC_HIGH, SYNC_HIGH},
    level: 3'b011,
    phase: ST_IDLE,
    after: ST_IDLE,
    bitCnt: '0,
    rxShift: '0,
    txShift: '0,
    sdaOe: 1'b0,
    cmd: '0,
    cmdStrobe: 1'b0,
    startPulse: 1'b0,
    stopPulse: 1'b0
  };

endpackage
